// [hdl/pin_route_and_pad_control.sv]
`timescale 1ns/100ps
module pin_route_and_pad_control import pin_route_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [15:0] i_io_wdata,
  output logic [15:0] o_io_rdata,
  output logic o_io_rvalid,
  input wire logic [20:0] i_lcd_out,
  input wire logic [20:0] i_lcd_oe,
  output logic [20:0] o_lcd_in,
  input wire logic [6:0] i_spi_out,
  input wire logic [6:0] i_spi_oe,
  output logic [6:0] o_spi_in,
  input wire logic [3:0] i_uart_out,
  input wire logic [3:0] i_uart_oe,
  output logic [3:0] o_uart_in,
  input wire logic [3:0] i_aud2_out,
  input wire logic [3:0] i_aud2_oe,
  output logic [3:0] o_aud2_in,
  input wire logic [3:0] i_aud3_out,
  input wire logic [3:0] i_aud3_oe,
  output logic [3:0] o_aud3_in,
  input wire logic [5:0] i_mmc0_out,
  input wire logic [5:0] i_mmc0_oe,
  output logic [5:0] o_mmc0_in,
  input wire logic [3:0] i_aud0_out,
  input wire logic [3:0] i_aud0_oe,
  output logic [3:0] o_aud0_in,
  input wire logic [5:0] i_mmc1_out,
  input wire logic [5:0] i_mmc1_oe,
  output logic [5:0] o_mmc1_in,
  input wire logic [3:0] i_aud1_out,
  input wire logic [3:0] i_aud1_oe,
  output logic [3:0] o_aud1_in,
  input wire logic [31:0] i_gpio_out,
  input wire logic [31:0] i_gpio_oe,
  output logic [31:0] o_gpio_in,
  input wire logic [5:0] i_ext_mem_addr_out,
  input wire logic [20:0] i_par_pad_in,
  output logic [20:0] o_par_pad_out,
  output logic [20:0] o_par_pad_oe,
  input wire logic [5:0] i_ser0_pad_in,
  output logic [5:0] o_ser0_pad_out,
  output logic [5:0] o_ser0_pad_oe,
  input wire logic [5:0] i_ser1_pad_in,
  output logic [5:0] o_ser1_pad_out,
  output logic [5:0] o_ser1_pad_oe,
  input wire logic [5:0] i_ext_mem_addr_pin_in,
  output logic [5:0] o_ext_mem_addr_pin_out,
  output logic [5:0] o_ext_mem_addr_pin_oe,
  output logic o_clock_out_slew,
  output logic o_ext_mem_slew,
  output logic [15:0] o_serial_pin_pull_inhibit,
  output logic [15:0] o_misc_pin_pull_inhibit,
  output logic [15:0] o_parallel_pin_pull_inhibit
);

  // ==========================================================================
  // parallel pin source table
  // pin order: 0 pixel clock, 1..16 lcd data 0..15, 17 bias, 18 mclk,
  // 19 hsync, 20 vsync; result is {source, index within that source}
  function automatic logic [7:0] par_src(input logic [2:0] mode, input logic [4:0] p);
    logic [4:0] q;
    logic [4:0] spi_q;
    q = 5'(p - 5'd9);
    spi_q = (q == 5'd0) ? 5'd0 : (q == 5'd1) ? 5'd3 : (q == 5'd2) ? 5'd1 : 5'd2;
    par_src = {SRC_LCD, p};
    case (mode)
      PAR_LCD16: par_src = {SRC_LCD, p};
      // gpio spi uart audio-2, same with audio-3
      PAR_GPIO_SPI_UART_AUD2, PAR_GPIO_SPI_AUD23: begin
        if (p <= 5'd2) par_src = {SRC_SPI, p};
        else if (p <= 5'd8) par_src = {SRC_GPIO, 5'(p + 5'd9)};
        else if (p <= 5'd12) par_src = {SRC_AUD2, q};
        else if (p <= 5'd16) par_src = (mode == PAR_GPIO_SPI_AUD23) ? {SRC_AUD3, 5'(p - 5'd13)} :
                                                                      {SRC_UART, 5'(p - 5'd13)};
        else par_src = {SRC_SPI, 5'(p - 5'd14)};
      end
      PAR_LCD8_GPIO: begin
        if (p >= 5'd9 && p <= 5'd11) par_src = {SRC_GPIO, 5'(p + 5'd9)};
        else if (p >= 5'd12 && p <= 5'd16) par_src = {SRC_GPIO, 5'(p + 5'd15)};
      end
      PAR_LCD8_SPI_AUD3: begin
        if (p >= 5'd9 && p <= 5'd12) par_src = {SRC_SPI, spi_q};
        else if (p >= 5'd13 && p <= 5'd16) par_src = {SRC_AUD3, 5'(p - 5'd13)};
      end
      PAR_LCD8_AUD2_UART: begin
        if (p >= 5'd9 && p <= 5'd12) par_src = {SRC_AUD2, q};
        else if (p >= 5'd13 && p <= 5'd16) par_src = {SRC_UART, 5'(p - 5'd13)};
      end
      PAR_LCD8_UART_SPI: begin
        if (p >= 5'd9 && p <= 5'd12) par_src = {SRC_SPI, spi_q};
        else if (p >= 5'd13 && p <= 5'd16) par_src = {SRC_UART, 5'(p - 5'd13)};
      end
      // reserved value parks every pin undriven
      default: par_src = {SRC_NONE, 5'd0};
    endcase
  endfunction

  // ==========================================================================
  // registers
  logic [15:0] bus_route_select_r, output_slew_control_r;
  logic [15:0] serial_pin_pull_inhibit_r, misc_pin_pull_inhibit_r, parallel_pin_pull_inhibit_r;
  logic [15:0] rdata_nxt, io_rdata_r;
  logic io_rvalid_r;

  // address decode
  wire hit_route = (i_io_addr == ADDR_BUS_ROUTE_SELECT);
  wire hit_slew = (i_io_addr == ADDR_OUTPUT_SLEW_CONTROL);
  wire hit_ser = (i_io_addr == ADDR_SERIAL_PIN_PULL_INHIBIT);
  wire hit_misc = (i_io_addr == ADDR_MISC_PIN_PULL_INHIBIT);
  wire hit_par = (i_io_addr == ADDR_PARALLEL_PIN_PULL_INHIBIT);

  // read back, unmapped reads give zero
  assign rdata_nxt = hit_route ? bus_route_select_r :
                     hit_slew ? output_slew_control_r :
                     hit_ser ? serial_pin_pull_inhibit_r :
                     hit_misc ? misc_pin_pull_inhibit_r :
                     hit_par ? parallel_pin_pull_inhibit_r : 16'h0000;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bus_route_select_r <= RST_BUS_ROUTE_SELECT;
      output_slew_control_r <= RST_OUTPUT_SLEW_CONTROL;
      serial_pin_pull_inhibit_r <= RST_SERIAL_PIN_PULL_INHIBIT;
      misc_pin_pull_inhibit_r <= RST_MISC_PIN_PULL_INHIBIT;
      parallel_pin_pull_inhibit_r <= RST_PARALLEL_PIN_PULL_INHIBIT;
    end else if (i_io_wr) begin
      if (hit_route) bus_route_select_r <= i_io_wdata & MASK_BUS_ROUTE_SELECT;
      if (hit_slew) output_slew_control_r <= i_io_wdata & MASK_OUTPUT_SLEW_CONTROL;
      if (hit_ser) serial_pin_pull_inhibit_r <= i_io_wdata & MASK_SERIAL_PIN_PULL_INHIBIT;
      if (hit_misc) misc_pin_pull_inhibit_r <= i_io_wdata & MASK_MISC_PIN_PULL_INHIBIT;
      if (hit_par) parallel_pin_pull_inhibit_r <= i_io_wdata & MASK_PARALLEL_PIN_PULL_INHIBIT;
    end
  end

  // read data answers one cycle after the strobe
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      io_rdata_r <= 16'h0000;
      io_rvalid_r <= 1'b0;
    end else begin
      io_rdata_r <= i_io_rd ? rdata_nxt : 16'h0000;
      io_rvalid_r <= i_io_rd;
    end
  end

  // ==========================================================================
  // route fields
  // parallel field
  wire [2:0] parallel_route_sel = bus_route_select_r[PARALLEL_ROUTE_SEL_LSB +: 3];
  // serial 1 field, serial 0 field
  wire [1:0] serial1_route_sel = bus_route_select_r[SERIAL1_ROUTE_SEL_LSB +: 2];
  wire [1:0] serial0_route_sel = bus_route_select_r[SERIAL0_ROUTE_SEL_LSB +: 2];
  wire [5:0] addr_as_io = bus_route_select_r[ADDR_AS_IO_LSB +: ADDR_IO_PINS];

  // ==========================================================================
  // parallel port mux
  logic [7:0] par_sel [PAR_PINS];
  logic [20:0] par_out_nxt, par_oe_nxt;

  genvar g;
  generate
    for (g = 0; g < PAR_PINS; g++) begin : g_par
      wire [2:0] src = par_sel[g][7:5];
      wire [4:0] idx = par_sel[g][4:0];
      assign par_sel[g] = par_src(parallel_route_sel, 5'(g));
      assign par_out_nxt[g] = (src == SRC_LCD) ? i_lcd_out[idx] :
                              (src == SRC_SPI) ? i_spi_out[idx[2:0] % 7] :
                              (src == SRC_UART) ? i_uart_out[idx[1:0]] :
                              (src == SRC_AUD2) ? i_aud2_out[idx[1:0]] :
                              (src == SRC_AUD3) ? i_aud3_out[idx[1:0]] :
                              (src == SRC_GPIO) ? i_gpio_out[idx] : 1'b0;
      assign par_oe_nxt[g] = (src == SRC_LCD) ? i_lcd_oe[idx] :
                             (src == SRC_SPI) ? i_spi_oe[idx[2:0] % 7] :
                             (src == SRC_UART) ? i_uart_oe[idx[1:0]] :
                             (src == SRC_AUD2) ? i_aud2_oe[idx[1:0]] :
                             (src == SRC_AUD3) ? i_aud3_oe[idx[1:0]] :
                             (src == SRC_GPIO) ? i_gpio_oe[idx] : 1'b0;
    end
  endgenerate

  // return path: a peripheral not routed to a pin sees zero
  logic [20:0] lcd_in_nxt;
  logic [6:0] spi_in_nxt;
  logic [3:0] uart_in_nxt, aud2_in_nxt, aud3_in_nxt;
  logic [31:0] gpio_par_in_nxt;
  always_comb begin
    lcd_in_nxt = '0;
    spi_in_nxt = '0;
    uart_in_nxt = '0;
    aud2_in_nxt = '0;
    aud3_in_nxt = '0;
    gpio_par_in_nxt = '0;
    for (int p = 0; p < PAR_PINS; p++) begin
      case (par_sel[p][7:5])
        SRC_LCD: lcd_in_nxt[par_sel[p][4:0]] = i_par_pad_in[p];
        SRC_SPI: spi_in_nxt[par_sel[p][2:0] % 7] = i_par_pad_in[p];
        SRC_UART: uart_in_nxt[par_sel[p][1:0]] = i_par_pad_in[p];
        SRC_AUD2: aud2_in_nxt[par_sel[p][1:0]] = i_par_pad_in[p];
        SRC_AUD3: aud3_in_nxt[par_sel[p][1:0]] = i_par_pad_in[p];
        SRC_GPIO: gpio_par_in_nxt[par_sel[p][4:0]] = i_par_pad_in[p];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // upper address pins
  // address stays driven until switched to gpio
  wire [5:0] addr_out_nxt = (addr_as_io & i_gpio_out[ADDR_GPIO_BASE +: 6]) | (~addr_as_io & i_ext_mem_addr_out);
  wire [5:0] addr_oe_nxt = (addr_as_io & i_gpio_oe[ADDR_GPIO_BASE +: 6]) | ~addr_as_io;
  wire [5:0] addr_gp_in_nxt = addr_as_io & i_ext_mem_addr_pin_in;

  // pads registered, one cycle behind the field
  logic [20:0] par_out_r, par_oe_r, lcd_in_r;
  logic [6:0] spi_in_r;
  logic [3:0] uart_in_r, aud2_in_r, aud3_in_r;
  logic [31:0] gpio_in_r;
  logic [5:0] addr_out_r, addr_oe_r;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      par_out_r <= '0;
      par_oe_r <= '0;
      lcd_in_r <= '0;
      spi_in_r <= '0;
      uart_in_r <= '0;
      aud2_in_r <= '0;
      aud3_in_r <= '0;
      gpio_in_r <= '0;
      addr_out_r <= '0;
      addr_oe_r <= '0;
    end else begin
      par_out_r <= par_out_nxt;
      par_oe_r <= par_oe_nxt;
      lcd_in_r <= lcd_in_nxt;
      spi_in_r <= spi_in_nxt;
      uart_in_r <= uart_in_nxt;
      aud2_in_r <= aud2_in_nxt;
      aud3_in_r <= aud3_in_nxt;
      gpio_in_r <= gpio_par_in_nxt | {5'h00, addr_gp_in_nxt, 21'h000000};
      addr_out_r <= addr_out_nxt;
      addr_oe_r <= addr_oe_nxt;
    end
  end

  // ==========================================================================
  // serial ports
  serial_port_if ser0 ();
  serial_port_if ser1 ();

  assign ser0.route = serial0_route_sel;
  assign ser0.mmc_out = i_mmc0_out;
  assign ser0.mmc_oe = i_mmc0_oe;
  assign ser0.i2s_out = i_aud0_out;
  assign ser0.i2s_oe = i_aud0_oe;
  assign ser0.gp_out = i_gpio_out[SER0_GPIO_BASE +: 6];
  assign ser0.gp_oe = i_gpio_oe[SER0_GPIO_BASE +: 6];
  assign ser0.pad_in = i_ser0_pad_in;

  assign ser1.route = serial1_route_sel;
  assign ser1.mmc_out = i_mmc1_out;
  assign ser1.mmc_oe = i_mmc1_oe;
  assign ser1.i2s_out = i_aud1_out;
  assign ser1.i2s_oe = i_aud1_oe;
  assign ser1.gp_out = i_gpio_out[SER1_GPIO_BASE +: 6];
  assign ser1.gp_oe = i_gpio_oe[SER1_GPIO_BASE +: 6];
  assign ser1.pad_in = i_ser1_pad_in;

  serial_pin_router u_ser0 (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .port(ser0.router)
  );

  serial_pin_router u_ser1 (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .port(ser1.router)
  );

  // ==========================================================================
  // outputs, all from flops here or in the routers
  assign o_io_rdata = io_rdata_r;
  assign o_io_rvalid = io_rvalid_r;
  assign o_par_pad_out = par_out_r;
  assign o_par_pad_oe = par_oe_r;
  assign o_lcd_in = lcd_in_r;
  assign o_spi_in = spi_in_r;
  assign o_uart_in = uart_in_r;
  assign o_aud2_in = aud2_in_r;
  assign o_aud3_in = aud3_in_r;
  assign o_ext_mem_addr_pin_out = addr_out_r;
  assign o_ext_mem_addr_pin_oe = addr_oe_r;
  assign o_gpio_in = {gpio_in_r[31:12], ser1.gp_in, ser0.gp_in};
  assign o_ser0_pad_out = ser0.pad_out;
  assign o_ser0_pad_oe = ser0.pad_oe;
  assign o_mmc0_in = ser0.mmc_in;
  assign o_aud0_in = ser0.i2s_in;
  assign o_ser1_pad_out = ser1.pad_out;
  assign o_ser1_pad_oe = ser1.pad_oe;
  assign o_mmc1_in = ser1.mmc_in;
  assign o_aud1_in = ser1.i2s_in;

  assign o_clock_out_slew = output_slew_control_r[CLOCK_OUT_SLEW_BIT];
  assign o_ext_mem_slew = output_slew_control_r[EXT_MEM_SLEW_BIT];
  // serial pulldown inhibits go straight to the pads
  assign o_serial_pin_pull_inhibit = serial_pin_pull_inhibit_r;
  assign o_misc_pin_pull_inhibit = misc_pin_pull_inhibit_r;
  // parallel pulldown inhibits, low two bits stay zero
  assign o_parallel_pin_pull_inhibit = parallel_pin_pull_inhibit_r;

endmodule

// [hdl/pin_route_pkg.sv]
package pin_route_pkg;

  // ==========================================================================
  // register port word addresses
  localparam logic [15:0] ADDR_BUS_ROUTE_SELECT = 16'h1c00;
  localparam logic [15:0] ADDR_OUTPUT_SLEW_CONTROL = 16'h1c16;
  localparam logic [15:0] ADDR_SERIAL_PIN_PULL_INHIBIT = 16'h1c17;
  localparam logic [15:0] ADDR_MISC_PIN_PULL_INHIBIT = 16'h1c18;
  localparam logic [15:0] ADDR_PARALLEL_PIN_PULL_INHIBIT = 16'h1c19;

  // ==========================================================================
  // writable bit masks and reset values
  localparam logic [15:0] MASK_BUS_ROUTE_SELECT = 16'h7f3f;
  localparam logic [15:0] RST_BUS_ROUTE_SELECT = 16'h0000;
  localparam logic [15:0] MASK_OUTPUT_SLEW_CONTROL = 16'h0005;
  localparam logic [15:0] RST_OUTPUT_SLEW_CONTROL = 16'h0005;
  localparam logic [15:0] MASK_SERIAL_PIN_PULL_INHIBIT = 16'h3f3f;
  localparam logic [15:0] RST_SERIAL_PIN_PULL_INHIBIT = 16'h3f3f;
  localparam logic [15:0] MASK_MISC_PIN_PULL_INHIBIT = 16'h7f3f;
  localparam logic [15:0] RST_MISC_PIN_PULL_INHIBIT = 16'h603f;
  localparam logic [15:0] MASK_PARALLEL_PIN_PULL_INHIBIT = 16'hfffc;
  localparam logic [15:0] RST_PARALLEL_PIN_PULL_INHIBIT = 16'hfffc;

  // ==========================================================================
  // field positions
  localparam int PARALLEL_ROUTE_SEL_LSB = 12;
  localparam int SERIAL1_ROUTE_SEL_LSB = 10;
  localparam int SERIAL0_ROUTE_SEL_LSB = 8;
  localparam int ADDR_AS_IO_LSB = 0;
  localparam int CLOCK_OUT_SLEW_BIT = 2;
  localparam int EXT_MEM_SLEW_BIT = 0;
  localparam int SER1_PULLDOWN_LSB = 8;
  localparam int SER0_PULLDOWN_LSB = 0;
  localparam int PULLUP_OFF_LSB = 8;
  localparam int ADDR_PULLDOWN_LSB = 0;
  localparam int PAR_PULLDOWN_LSB = 2;

  // ==========================================================================
  // route encodings
  localparam logic [2:0] PAR_LCD16 = 3'h0;
  localparam logic [2:0] PAR_GPIO_SPI_UART_AUD2 = 3'h1;
  localparam logic [2:0] PAR_LCD8_GPIO = 3'h2;
  localparam logic [2:0] PAR_LCD8_SPI_AUD3 = 3'h3;
  localparam logic [2:0] PAR_LCD8_AUD2_UART = 3'h4;
  localparam logic [2:0] PAR_LCD8_UART_SPI = 3'h5;
  localparam logic [2:0] PAR_GPIO_SPI_AUD23 = 3'h6;
  localparam logic [1:0] SER_MMC = 2'h0;
  localparam logic [1:0] SER_I2S = 2'h1;
  localparam logic [1:0] SER_GPIO = 2'h2;

  // ==========================================================================
  // pin counts and gpio numbering
  localparam int PAR_PINS = 21;
  localparam int SER_PINS = 6;
  localparam int ADDR_IO_PINS = 6;
  localparam int SER0_GPIO_BASE = 0;
  localparam int SER1_GPIO_BASE = 6;
  localparam int ADDR_GPIO_BASE = 21;

  // source of one parallel pin
  typedef enum logic [2:0] {
    SRC_NONE, SRC_LCD, SRC_SPI, SRC_UART, SRC_AUD2, SRC_AUD3, SRC_GPIO
  } src_type;

endpackage

// [hdl/serial_port_if.sv]
`timescale 1ns/100ps
interface serial_port_if;
  logic [1:0] route;
  logic [5:0] mmc_out, mmc_oe, mmc_in;
  logic [3:0] i2s_out, i2s_oe, i2s_in;
  logic [5:0] gp_out, gp_oe, gp_in;
  logic [5:0] pad_out, pad_oe, pad_in;

  modport router (
    input route, mmc_out, mmc_oe, i2s_out, i2s_oe, gp_out, gp_oe, pad_in,
    output mmc_in, i2s_in, gp_in, pad_out, pad_oe
  );
  modport owner (
    output route, mmc_out, mmc_oe, i2s_out, i2s_oe, gp_out, gp_oe, pad_in,
    input mmc_in, i2s_in, gp_in, pad_out, pad_oe
  );
endinterface

// [hdl/serial_pin_router.sv]
`timescale 1ns/100ps
module serial_pin_router import pin_route_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  serial_port_if.router port
);

  // ==========================================================================
  // per pin selection
  logic [5:0] out_nxt, oe_nxt, mmc_in_nxt, gp_in_nxt;
  logic [3:0] i2s_in_nxt;
  logic [5:0] pad_out_r, pad_oe_r, mmc_in_r, gp_in_r;
  logic [3:0] i2s_in_r;

  genvar g;
  generate
    for (g = 0; g < SER_PINS; g++) begin : g_pin
      // pins 4 and 5 have no audio, so audio route gives gpio
      wire use_mmc = (port.route == SER_MMC);
      wire use_i2s = (port.route == SER_I2S) && (g < 4);
      wire use_gp = (port.route == SER_GPIO) || ((port.route == SER_I2S) && (g >= 4));
      assign out_nxt[g] = use_mmc ? port.mmc_out[g] : use_i2s ? port.i2s_out[g % 4] :
                          use_gp ? port.gp_out[g] : 1'b0;
      assign oe_nxt[g] = use_mmc ? port.mmc_oe[g] : use_i2s ? port.i2s_oe[g % 4] :
                         use_gp ? port.gp_oe[g] : 1'b0;
      assign mmc_in_nxt[g] = use_mmc & port.pad_in[g];
      assign gp_in_nxt[g] = use_gp & port.pad_in[g];
    end
    for (g = 0; g < 4; g++) begin : g_aud
      assign i2s_in_nxt[g] = (port.route == SER_I2S) & port.pad_in[g];
    end
  endgenerate

  // ==========================================================================
  // registered pads, so a route change lands one cycle later
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pad_out_r <= 6'h00;
      pad_oe_r <= 6'h00;
      mmc_in_r <= 6'h00;
      gp_in_r <= 6'h00;
      i2s_in_r <= 4'h0;
    end else begin
      pad_out_r <= out_nxt;
      pad_oe_r <= oe_nxt;
      mmc_in_r <= mmc_in_nxt;
      gp_in_r <= gp_in_nxt;
      i2s_in_r <= i2s_in_nxt;
    end
  end

  assign port.pad_out = pad_out_r;
  assign port.pad_oe = pad_oe_r;
  assign port.mmc_in = mmc_in_r;
  assign port.gp_in = gp_in_r;
  assign port.i2s_in = i2s_in_r;

endmodule

// [verification/pin_route_properties.sv]
`timescale 1ns/100ps
module pin_route_properties import pin_route_pkg::*; (
  input logic i_core_clk,
  input logic i_rst_b,
  input logic [15:0] i_io_addr,
  input logic i_io_wr,
  input logic i_io_rd,
  input logic [15:0] i_io_wdata,
  input logic [15:0] o_io_rdata,
  input logic o_io_rvalid,
  input logic [20:0] i_lcd_out,
  input logic [20:0] i_lcd_oe,
  input logic [5:0] i_ext_mem_addr_out,
  input logic [20:0] o_par_pad_out,
  input logic [20:0] o_par_pad_oe,
  input logic [5:0] o_ext_mem_addr_pin_out,
  input logic [5:0] o_ext_mem_addr_pin_oe,
  input logic o_clock_out_slew,
  input logic o_ext_mem_slew,
  input logic [15:0] o_serial_pin_pull_inhibit,
  input logic [15:0] o_misc_pin_pull_inhibit,
  input logic [15:0] o_parallel_pin_pull_inhibit
);
  // ==========================================================================
  // write decode and route shadow
  wire wr_route = i_io_wr && i_io_addr == ADDR_BUS_ROUTE_SELECT;
  wire wr_slew = i_io_wr && i_io_addr == ADDR_OUTPUT_SLEW_CONTROL;
  wire wr_ser = i_io_wr && i_io_addr == ADDR_SERIAL_PIN_PULL_INHIBIT;
  wire wr_misc = i_io_wr && i_io_addr == ADDR_MISC_PIN_PULL_INHIBIT;
  wire wr_par = i_io_wr && i_io_addr == ADDR_PARALLEL_PIN_PULL_INHIBIT;
  logic [15:0] route_r;
  // shadow follows the route register, so pad checks need no peek inside
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      route_r <= RST_BUS_ROUTE_SELECT;
    end else if (wr_route) begin
      route_r <= i_io_wdata & MASK_BUS_ROUTE_SELECT;
    end
  end
  // ==========================================================================
  // properties, one clock domain
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  property p_read_pulse; o_io_rvalid == ($past(i_io_rd) && $past(i_rst_b)); endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("rvalid late");
  property p_idle_rdata; !o_io_rvalid |-> o_io_rdata == 16'h0000; endproperty
  a_idle_rdata: assert property (p_idle_rdata) else $error("rdata not zero");
  property p_slew_rsv; i_io_rd && i_io_addr == ADDR_OUTPUT_SLEW_CONTROL |=> (o_io_rdata & 16'hfffa) == 16'h0000; endproperty
  a_slew_rsv: assert property (p_slew_rsv) else $error("slew reserved set");
  property p_slew; wr_slew |=> {o_clock_out_slew, 1'b0, o_ext_mem_slew} == ($past(i_io_wdata[2:0]) & 3'h5); endproperty
  a_slew: assert property (p_slew) else $error("slew stale");
  property p_ser; wr_ser |=> o_serial_pin_pull_inhibit == ($past(i_io_wdata) & MASK_SERIAL_PIN_PULL_INHIBIT); endproperty
  a_ser: assert property (p_ser) else $error("serial inhibit stale");
  property p_misc; wr_misc |=> o_misc_pin_pull_inhibit == ($past(i_io_wdata) & MASK_MISC_PIN_PULL_INHIBIT); endproperty
  a_misc: assert property (p_misc) else $error("misc inhibit stale");
  property p_par; wr_par |=> o_parallel_pin_pull_inhibit == ($past(i_io_wdata) & MASK_PARALLEL_PIN_PULL_INHIBIT); endproperty
  a_par: assert property (p_par) else $error("parallel inhibit stale");
  property p_lcd16;
    $past(i_rst_b) && $past(route_r[14:12]) == PAR_LCD16 |-> o_par_pad_out == $past(i_lcd_out) && o_par_pad_oe == $past(i_lcd_oe);
  endproperty
  a_lcd16: assert property (p_lcd16) else $error("pads not lcd");
  property p_addr_mode;
    $past(i_rst_b) && $past(route_r[5:0]) == 6'h00 |-> o_ext_mem_addr_pin_oe == 6'h3f && o_ext_mem_addr_pin_out == $past(i_ext_mem_addr_out);
  endproperty
  a_addr_mode: assert property (p_addr_mode) else $error("address pins not address");
  property p_par_rsv; $past(i_rst_b) && $past(route_r[14:12]) == 3'h7 |-> o_par_pad_oe == 21'h000000; endproperty
  a_par_rsv: assert property (p_par_rsv) else $error("reserved route drives");
  c_read: cover property (o_io_rvalid);
  c_par6: cover property (route_r[14:12] == PAR_GPIO_SPI_AUD23);
  c_addr_io: cover property (o_ext_mem_addr_pin_oe != 6'h3f);
endmodule
bind pin_route_and_pad_control pin_route_properties u_pin_route_properties (.*);

// [verification/testbench.sv]
`timescale 1ns/100ps
module testbench import pin_route_pkg::*;;
  logic i_core_clk, i_rst_b, i_io_wr, i_io_rd, o_io_rvalid, o_clock_out_slew, o_ext_mem_slew;
  logic [15:0] i_io_addr, i_io_wdata, o_io_rdata;
  logic [15:0] o_serial_pin_pull_inhibit, o_misc_pin_pull_inhibit, o_parallel_pin_pull_inhibit;
  logic [20:0] i_lcd_out, i_lcd_oe, o_lcd_in, i_par_pad_in, o_par_pad_out, o_par_pad_oe;
  logic [6:0] i_spi_out, i_spi_oe, o_spi_in;
  logic [3:0] i_uart_out, i_uart_oe, o_uart_in, i_aud2_out, i_aud2_oe, o_aud2_in, i_aud3_out, i_aud3_oe, o_aud3_in;
  logic [3:0] i_aud0_out, i_aud0_oe, o_aud0_in, i_aud1_out, i_aud1_oe, o_aud1_in;
  logic [5:0] i_mmc0_out, i_mmc0_oe, o_mmc0_in, i_mmc1_out, i_mmc1_oe, o_mmc1_in, i_ext_mem_addr_out;
  logic [5:0] i_ser0_pad_in, o_ser0_pad_out, o_ser0_pad_oe, i_ser1_pad_in, o_ser1_pad_out, o_ser1_pad_oe;
  logic [5:0] i_ext_mem_addr_pin_in, o_ext_mem_addr_pin_out, o_ext_mem_addr_pin_oe;
  logic [31:0] i_gpio_out, i_gpio_oe, o_gpio_in, pat;
  int miscompares, n_compared, cyc;
  localparam logic [15:0] RADDR [5] = '{ADDR_BUS_ROUTE_SELECT, ADDR_OUTPUT_SLEW_CONTROL,
    ADDR_SERIAL_PIN_PULL_INHIBIT, ADDR_MISC_PIN_PULL_INHIBIT, ADDR_PARALLEL_PIN_PULL_INHIBIT};
  localparam logic [15:0] RMASK [5] = '{MASK_BUS_ROUTE_SELECT, MASK_OUTPUT_SLEW_CONTROL,
    MASK_SERIAL_PIN_PULL_INHIBIT, MASK_MISC_PIN_PULL_INHIBIT, MASK_PARALLEL_PIN_PULL_INHIBIT};
  localparam logic [15:0] RRST [5] = '{RST_BUS_ROUTE_SELECT, RST_OUTPUT_SLEW_CONTROL,
    RST_SERIAL_PIN_PULL_INHIBIT, RST_MISC_PIN_PULL_INHIBIT, RST_PARALLEL_PIN_PULL_INHIBIT};
  // ==========================================================================
  // peripheral and pad inputs all come from one shifting pattern
  assign {i_lcd_out, i_lcd_oe, i_spi_out, i_spi_oe, i_uart_out, i_uart_oe, i_aud2_out, i_aud2_oe, i_aud3_out,
    i_aud3_oe, i_mmc0_out, i_mmc0_oe, i_aud0_out, i_aud0_oe, i_mmc1_out, i_mmc1_oe, i_aud1_out, i_aud1_oe,
    i_gpio_out, i_gpio_oe, i_ext_mem_addr_out, i_par_pad_in, i_ser0_pad_in, i_ser1_pad_in,
    i_ext_mem_addr_pin_in} = 229'({8{pat}});
  pin_route_and_pad_control u_pin_route_and_pad_control (.*);
  // clock and hang guard
  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 1000) begin
      miscompares++;
      close_out;
    end
  end
  // ==========================================================================
  // compares and register port cycles
  task chk_reg(input logic [15:0] got, input logic [15:0] exp);
    chk_pin(21'(got), 21'(exp));
  endtask
  task chk_pin(input logic [20:0] got, input logic [20:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // each write shifts the pattern so routes see fresh values
  task wr(input logic [15:0] a, input logic [15:0] d);
    pat = {pat[30:0], ^(pat & 32'h80200003)};
    i_io_addr = a;
    i_io_wdata = d;
    i_io_wr = 1'b1;
    @(posedge i_core_clk);
    #1 i_io_wr = 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [15:0] exp);
    i_io_addr = a;
    i_io_rd = 1'b1;
    @(posedge i_core_clk);
    #1 i_io_rd = 1'b0;
    chk_reg(o_io_rdata, exp);
  endtask
  // ==========================================================================
  // scenarios
  task t_regs;
    for (int i = 0; i < 5; i++) rd(RADDR[i], RRST[i]);
    chk_reg(16'({o_clock_out_slew, o_ext_mem_slew}), 16'h0003);
    for (int i = 0; i < 5; i++) begin
      wr(RADDR[i], 16'hffff);
      rd(RADDR[i], RMASK[i]);
      wr(RADDR[i], 16'h5a5a);
      rd(RADDR[i], 16'h5a5a & RMASK[i]);
    end
    chk_reg(o_serial_pin_pull_inhibit, 16'h5a5a & MASK_SERIAL_PIN_PULL_INHIBIT);
    chk_reg(o_misc_pin_pull_inhibit, 16'h5a5a & MASK_MISC_PIN_PULL_INHIBIT);
    chk_reg(o_parallel_pin_pull_inhibit, 16'h5a5a & MASK_PARALLEL_PIN_PULL_INHIBIT);
    chk_reg(16'({o_clock_out_slew, o_ext_mem_slew}), 16'h0000);
    wr(16'h1c1a, 16'hffff);
    rd(16'h1c1a, 16'h0000);
    $display("regs done");
  endtask
  // pins 0, 12 and 13 together tell every parallel route apart
  // value 7 only to see pins stay undriven
  task t_par;
    logic [2:0] e;
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_BUS_ROUTE_SELECT, 16'(m << PARALLEL_ROUTE_SEL_LSB));
      case (m)
        0: e = {i_lcd_out[13], i_lcd_out[12], i_lcd_out[0]};
        1: e = {i_uart_out[0], i_aud2_out[3], i_spi_out[0]};
        2: e = {i_gpio_out[28], i_gpio_out[27], i_lcd_out[0]};
        3: e = {i_aud3_out[0], i_spi_out[2], i_lcd_out[0]};
        4: e = {i_uart_out[0], i_aud2_out[3], i_lcd_out[0]};
        5: e = {i_uart_out[0], i_spi_out[2], i_lcd_out[0]};
        6: e = {i_aud3_out[0], i_aud2_out[3], i_spi_out[0]};
        default: e = 3'h0;
      endcase
      @(posedge i_core_clk);
      #1;
      if (m == 7) chk_pin(o_par_pad_oe, 21'h000000);
      else chk_pin(21'({o_par_pad_out[13:12], o_par_pad_out[0]}), 21'(e));
      if (m == 0) chk_pin(o_lcd_in, i_par_pad_in);
    end
    $display("par done");
  endtask
  task t_ser;
    logic [3:0] e;
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_BUS_ROUTE_SELECT, 16'(m) * 16'h0500);
      case (m)
        0: e = {i_mmc1_out[5], i_mmc1_out[0], i_mmc0_out[5], i_mmc0_out[0]};
        1: e = {i_gpio_out[11], i_aud1_out[0], i_gpio_out[5], i_aud0_out[0]};
        2: e = {i_gpio_out[11], i_gpio_out[6], i_gpio_out[5], i_gpio_out[0]};
        default: e = 4'h0;
      endcase
      @(posedge i_core_clk);
      #1;
      if (m == 3) chk_pin(21'({o_ser1_pad_oe, o_ser0_pad_oe}), 21'h000000);
      else chk_pin(21'({o_ser1_pad_out[5], o_ser1_pad_out[0], o_ser0_pad_out[5], o_ser0_pad_out[0]}), 21'(e));
      if (m == 2) chk_pin(21'(o_gpio_in[11:0]), 21'({i_ser1_pad_in, i_ser0_pad_in}));
    end
    $display("ser done");
  endtask
  // one route write; top and bottom address pins become io
  task t_addr;
    wr(ADDR_BUS_ROUTE_SELECT, 16'h0021);
    @(posedge i_core_clk);
    #1;
    chk_pin(21'(o_ext_mem_addr_pin_out), 21'({i_gpio_out[26], i_ext_mem_addr_out[4:1], i_gpio_out[21]}));
    chk_pin(21'(o_ext_mem_addr_pin_oe), 21'({i_gpio_oe[26], 4'hf, i_gpio_oe[21]}));
    chk_pin(21'({o_gpio_in[26], o_gpio_in[21]}), 21'({i_ext_mem_addr_pin_in[5], i_ext_mem_addr_pin_in[0]}));
    $display("addr done");
  endtask
  task close_out;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial begin
    {i_rst_b, i_io_wr, i_io_rd, i_io_addr, i_io_wdata, miscompares, n_compared, cyc} = '0;
    pat = 32'h1d2c3b4a;
    repeat (10) @(posedge i_core_clk);
    #1 i_rst_b = 1'b1;
    t_regs;
    t_par;
    t_ser;
    t_addr;
    close_out;
  end
endmodule
